// *** xmem_high_addr.sv ***
// Overview of operation
// R01 - keeper holds last driven value when released
// R02 - keeper off leaves released lines undriven
// R03 - keeper enable independent of interface enable
// R04 - mask zero drives all eight high pins
// R05 - mask k releases top k pins, mask 7 releases all eight
// R06 - released pins follow port output settings
// R07 - low 1280 addresses (1120 in compat mode) never go external
// R08 - unmasked external space is 64256 bytes (64416 in compat mode)
// R09 - full 16-bit address always driven; the code drives only the high pins that the mask keeps
// R10 - compat mode internal space ends 0x0460
// R11 - enable bit hands pins to interface
// R12 - mask ignored while interface disabled
`include "xmem_map.svh"
module xmem_high_addr
  import xmem_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RESET_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [7:0]  AD_IN,
  output logic      [7:0]  AD_OUT,
  output logic      [7:0]  AD_OE,
  output logic      [7:0]  HIGH_OUT,
  output logic      [7:0]  HIGH_OE,
  output logic             LATCH,
  output logic             WRITE_N,
  output logic             READ_N
);
  logic [7:0]   sfio;
  logic [7:0]   next_sfio;
  logic [7:0]   mctl;
  logic [7:0]   next_mctl;
  logic [7:0]   port_out;
  logic [7:0]   next_port_out;
  logic [7:0]   port_dir;
  logic [7:0]   next_port_dir;
  logic [31:0]  rdata;
  logic [31:0]  next_rdata;
  logic         slverr;
  logic         next_slverr;
  cycle_state_e state;
  cycle_state_e next_state;
  logic [2:0]   cnt;
  logic [2:0]   next_cnt;
  logic [15:0]  cyc_addr;
  logic [15:0]  next_cyc_addr;
  logic [7:0]   cyc_data;
  logic [7:0]   next_cyc_data;
  logic         cyc_write;
  logic         next_cyc_write;
  logic [7:0]   rd_data;
  logic [7:0]   next_rd_data;
  logic         ext_hit;
  logic         internal_hit;
  logic         next_internal_hit;
  logic [15:0]  int_end;
  logic [2:0]   mask;
  logic         xm_en;
  logic         keep_en;
  logic [7:0]   release_pins;
  logic         setup;
  logic         access_start;
  logic         access_phase;
  pin_drive_s   drv;
  logic [7:0]   keep_val;
  logic         keep_oe;

  assign setup    = PSEL & ~PENABLE;
  // pready is tied high, so every access phase completes at its first edge
  assign access_phase = PSEL & PENABLE;
  assign mask     = sfio[`SFIO_MASK_HI:`SFIO_MASK_LO];
  assign keep_en  = sfio[`SFIO_KEEPER_BIT];
  assign xm_en    = mctl[`MCTL_ENABLE_BIT];
  // compat mode shrinks the internal region
  assign int_end  = mctl[`MCTL_COMPAT_BIT] ? `INT_END_COMPAT : `INT_END_NORMAL;   // R10
  // low addresses belong to internal resources, no external cycle
  assign ext_hit  = (PWDATA[`ACC_ADDR_HI:0] >= int_end);                          // R07 R08
  assign access_start = access_phase & PWRITE & (PADDR == `ADDR_ACCESS) & xm_en &
                        (state == ST_IDLE);

  // top k pins released, all eight at mask 7; mask only counts while interface enabled
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_rel
      // the full-port code frees pin 0 as well, not just the top seven
      assign release_pins[gi] = xm_en && ((mask == `MASK_FULL_PORT) ||  // R05 R12
                                          (mask > 3'(`MASK_FULL_PORT - gi)));
    end
  endgenerate

  // read data latched at setup, writes land at the completing access edge
  always_comb begin
    next_sfio     = sfio;
    next_mctl     = mctl;
    next_port_out = port_out;
    next_port_dir = port_dir;
    next_rdata    = rdata;
    next_slverr   = 1'b0;
    if (setup) begin
      case (PADDR)
        `ADDR_SPECIAL_IO: begin
          next_rdata = {24'h0, sfio};
        end
        `ADDR_MEM_CTRL: begin
          next_rdata = {24'h0, mctl};
        end
        `ADDR_PORT_OUT: begin
          next_rdata = {24'h0, port_out};
        end
        `ADDR_PORT_DIR: begin
          next_rdata = {24'h0, port_dir};
        end
        `ADDR_ACCESS: begin
          next_rdata = {7'h0, cyc_write, cyc_data, cyc_addr};
        end
        `ADDR_STATUS: begin
          next_rdata = {22'h0, internal_hit, (state != ST_IDLE), rd_data};
        end
        default: begin
          next_rdata  = 32'h0;
          next_slverr = 1'b1;
        end
      endcase
    end
    // zero wait states, so the access phase always ends at this edge
    if (access_phase && PWRITE) begin
      case (PADDR)
        `ADDR_SPECIAL_IO: begin
          next_sfio = PWDATA[7:0];
        end
        `ADDR_MEM_CTRL: begin
          next_mctl = {6'h0, PWDATA[1:0]};
        end
        `ADDR_PORT_OUT: begin
          next_port_out = PWDATA[7:0];
        end
        `ADDR_PORT_DIR: begin
          next_port_dir = PWDATA[7:0];
        end
        default: begin
          next_sfio = sfio;
        end
      endcase
    end
  end

  // apb registers; reply held through access phase
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sfio     <= `SFIO_RESET;
      mctl     <= `MCTL_RESET;
      port_out <= 8'h00;
      port_dir <= 8'h00;
      rdata    <= 32'h0;
      slverr   <= 1'b0;
    end else begin
      sfio     <= next_sfio;
      mctl     <= next_mctl;
      port_out <= next_port_out;
      port_dir <= next_port_dir;
      rdata    <= next_rdata;
      slverr   <= next_slverr;
    end
  end

  assign PRDATA  = rdata;
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & slverr;

  // external cycle: address phase with latch, then strobe phase
  always_comb begin
    next_state        = state;
    next_cnt          = cnt;
    next_cyc_addr     = cyc_addr;
    next_cyc_data     = cyc_data;
    next_cyc_write    = cyc_write;
    next_rd_data      = rd_data;
    next_internal_hit = internal_hit;
    case (state)
      ST_IDLE: begin
        // an address below the internal end loads cyc_addr, cyc_data and cyc_write and flags the hit, but starts no cycle
        if (access_start) begin
          next_cyc_addr     = PWDATA[`ACC_ADDR_HI:0];   // R09
          next_cyc_data     = PWDATA[`ACC_DATA_HI:`ACC_DATA_LO];
          next_cyc_write    = PWDATA[`ACC_WRITE_BIT];
          next_internal_hit = ~ext_hit;
          if (ext_hit) next_state = ST_ADDR;              // R07
        end
      end
      ST_ADDR: begin
        next_state = ST_STROBE;
        next_cnt   = `XCYC_LEN;
      end
      ST_STROBE: begin
        // sample on the last strobe cycle, when the memory had longest
        if (cnt == 3'h1) begin
          if (!cyc_write) next_rd_data = AD_IN;
          next_state = ST_IDLE;
        end
        next_cnt = cnt - 3'h1;
      end
      default: next_state = ST_IDLE;
    endcase
    // a disabled interface drops any cycle in flight
    if (!xm_en) next_state = ST_IDLE;                     // R11
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state        <= ST_IDLE;
      cnt          <= 3'h0;
      cyc_addr     <= 16'h0000;
      cyc_data     <= 8'h00;
      cyc_write    <= 1'b0;
      rd_data      <= 8'h00;
      internal_hit <= 1'b0;
    end else begin
      state        <= next_state;
      cnt          <= next_cnt;
      cyc_addr     <= next_cyc_addr;
      cyc_data     <= next_cyc_data;
      cyc_write    <= next_cyc_write;
      rd_data      <= next_rd_data;
      internal_hit <= next_internal_hit;
    end
  end

  // pin drive: interface overrides port direction on unreleased high pins when enabled
  always_comb begin
    drv.addr_data_out = 8'h00;
    drv.addr_data_oe  = 1'b0;
    drv.latch         = 1'b0;
    drv.write_n       = 1'b1;
    drv.read_n        = 1'b1;
    if (xm_en) begin                                      // R11
      if (state == ST_ADDR) begin
        drv.addr_data_out = cyc_addr[7:0];
        drv.addr_data_oe  = 1'b1;
        drv.latch         = 1'b1;
      end else if (state == ST_STROBE) begin
        // data driven only on writes; reads leave the lines to the memory
        drv.addr_data_out = cyc_data;
        drv.addr_data_oe  = cyc_write;
        drv.write_n       = ~cyc_write;
        drv.read_n        = cyc_write;
      end
    end
    // released pins, or every pin while the interface is off, fall back to port settings
    for (int i = 0; i < 8; i++) begin
      if (xm_en && !release_pins[i]) begin
        drv.high_out[i] = cyc_addr[8+i];                  // R04 R09
        drv.high_oe[i]  = 1'b1;
      end else begin
        drv.high_out[i] = port_out[i];                    // R06 R12
        drv.high_oe[i]  = port_dir[i];
      end
    end
  end

  // keeper works from its own bit even with interface off
  bus_keeper #(
    .WIDTH (8)
  ) u_keeper (
    .clk       (CORE_CLK),
    .reset_n   (RESET_N),
    .keep_en   (keep_en),                                 // R03
    .drive_val (drv.addr_data_out),
    .drive_oe  (drv.addr_data_oe),
    .hold_val  (keep_val),
    .hold_oe   (keep_oe)
  );

  // outputs registered to keep pin timing clean
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      AD_OUT   <= 8'h00;
      AD_OE    <= 8'h00;
      HIGH_OUT <= 8'h00;
      HIGH_OE  <= 8'h00;
      LATCH    <= 1'b0;
      WRITE_N  <= 1'b1;
      READ_N   <= 1'b1;
    end else begin
      // held copy fills in whenever the interface lets go of the lines
      AD_OUT   <= drv.addr_data_oe ? drv.addr_data_out : keep_val;  // R01
      // keeper stands back during a read strobe so the memory's data win
      AD_OE    <= {8{drv.addr_data_oe | (keep_oe & drv.read_n)}};  // R02
      HIGH_OUT <= drv.high_out;
      HIGH_OE  <= drv.high_oe;
      LATCH    <= drv.latch;
      WRITE_N  <= drv.write_n;
      READ_N   <= drv.read_n;
    end
  end
endmodule : xmem_high_addr

// *** xmem_map.svh ***
`ifndef XMEM_MAP_SVH
`define XMEM_MAP_SVH
// apb byte addresses (word aligned)
`define ADDR_SPECIAL_IO   12'h000
`define ADDR_MEM_CTRL     12'h004
`define ADDR_PORT_OUT     12'h008
`define ADDR_PORT_DIR     12'h00C
`define ADDR_ACCESS       12'h010
`define ADDR_STATUS       12'h014
// special_function_io_control fields
`define SFIO_KEEPER_BIT   6
`define SFIO_MASK_HI      5
`define SFIO_MASK_LO      3
`define SFIO_RESET        8'h00
// mask code that frees the whole upper port
`define MASK_FULL_PORT    3'h7
// mem control fields
`define MCTL_ENABLE_BIT   0
`define MCTL_COMPAT_BIT   1
`define MCTL_RESET        8'h00
// internal space limits
`define INT_END_NORMAL    16'h0500
`define INT_END_COMPAT    16'h0460
// access register fields
`define ACC_ADDR_HI       15
`define ACC_DATA_LO       16
`define ACC_DATA_HI       23
`define ACC_WRITE_BIT     24
// cycle length
`define XCYC_LEN          3'h3
`endif

// *** xmem_pkg.sv ***
package xmem_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ADDR  = 2'b01,
    ST_STROBE = 2'b10
  } cycle_state_e;

  typedef struct packed {
    logic [7:0] addr_data_out;
    logic       addr_data_oe;
    logic [7:0] high_out;
    logic [7:0] high_oe;
    logic       latch;
    logic       write_n;
    logic       read_n;
  } pin_drive_s;
endpackage : xmem_pkg

// *** bus_keeper.sv ***
`include "xmem_map.svh"
module bus_keeper
  import xmem_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             keep_en,
  input  wire logic [WIDTH-1:0] drive_val,
  input  wire logic             drive_oe,
  output logic      [WIDTH-1:0] hold_val,
  output logic                  hold_oe
);
  logic [WIDTH-1:0] held;
  logic [WIDTH-1:0] next_held;

  // remember whatever was last actively driven
  always_comb begin
    next_held = drive_oe ? drive_val : held;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      held <= '0;
    end else begin
      held <= next_held;
    end
  end

  // keeper drives only when the lines are released; no sre qualification
  assign hold_val = held;                       // R01
  assign hold_oe  = keep_en & ~drive_oe;        // R01 R02 R03
endmodule : bus_keeper

// *** xmem_high_addr_asserts.sv ***
`include "xmem_map.svh"
module xmem_high_addr_asserts (
  input wire logic        CORE_CLK,
  input wire logic        RESET_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PSLVERR,
  input wire logic [7:0]  AD_OE,
  input wire logic        LATCH,
  input wire logic        WRITE_N,
  input wire logic        READ_N
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  // one address cycle, then three strobe cycles
  sequence s_addr; LATCH ##1 !LATCH; endsequence
  sequence s_strobe; (!WRITE_N || !READ_N) [*3] ##1 (WRITE_N && READ_N); endsequence
  // access write aimed below both internal ends
  sequence s_low_req;
    PSEL && !PENABLE && PWRITE && PADDR == `ADDR_ACCESS && PWDATA[15:0] < 16'h0460;
  endsequence
  property p_shape; $rose(LATCH) |-> s_addr ##0 s_strobe; endproperty
  property p_rd_len; $fell(READ_N) |-> !READ_N [*3] ##1 READ_N; endproperty
  property p_excl; !(!WRITE_N && !READ_N); endproperty
  property p_adr_out; LATCH |-> AD_OE == 8'hFF; endproperty
  property p_oe_same; AD_OE == 8'h00 || AD_OE == 8'hFF; endproperty
  // two edges of slack skip a previous cycle's latch pulse
  property p_no_ext; s_low_req |-> ##2 !LATCH [*5]; endproperty
  property p_err; PSEL && PENABLE && PADDR > `ADDR_STATUS |-> PSLVERR; endproperty
  property p_ok; PSEL && PENABLE && PADDR == `ADDR_STATUS |-> !PSLVERR; endproperty
  a_shape: assert property (p_shape) else $error("bad cycle shape");
  a_rd_len: assert property (p_rd_len) else $error("bad read strobe");
  a_excl: assert property (p_excl) else $error("both strobes low");
  a_adr_out: assert property (p_adr_out) else $error("address not driven");
  a_oe_same: assert property (p_oe_same) else $error("split line enable");
  a_no_ext: assert property (p_no_ext) else $error("internal went external");
  a_err: assert property (p_err) else $error("no error on unmapped");
  a_ok: assert property (p_ok) else $error("error on status");
endmodule : xmem_high_addr_asserts
bind xmem_high_addr xmem_high_addr_asserts u_asserts (
  .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSLVERR(PSLVERR),
  .AD_OE(AD_OE), .LATCH(LATCH), .WRITE_N(WRITE_N), .READ_N(READ_N)
);

// *** ext_sram_model.sv ***
module ext_sram_model (
  input  wire logic       clk,
  input  wire logic [7:0] ad,
  input  wire logic [7:0] hi,
  input  wire logic       ale,
  input  wire logic       we_n,
  input  wire logic       re_n,
  output logic      [7:0] q,
  output logic            q_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [0:65535];
  logic [15:0] addr = 16'h0000;
  // full address taken while the latch pulse stands
  always @(posedge clk) begin
    if (ale) begin
      addr <= {hi, ad};
    end
    if (!we_n) begin
      mem[addr] <= ad;
    end
  end
  // drives only during the read strobe, released otherwise
  assign q    = mem[addr];
  assign q_oe = !re_n;
endmodule : ext_sram_model

// *** testbench.sv ***
`include "xmem_map.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, latch, wr_n, rd_n, q_oe;
  logic [7:0]  ad_out, ad_oe, hi_out, hi_oe, q, ad_w, hi_seen, hi_exp, ad_last = 8'h00;
  int          n_fail = 0, total_checks = 0, cyc = 0;

  xmem_high_addr u_dut (
    .CORE_CLK(clk),
    .RESET_N(rst_n),
    .PSEL(psel),
    .PENABLE(penable),
    .PWRITE(pwrite),
    .PADDR(paddr),
    .PWDATA(pwdata),
    .PRDATA(prdata),
    .PREADY(pready),
    .PSLVERR(pslverr),
    .AD_IN(ad_w),
    .AD_OUT(ad_out),
    .AD_OE(ad_oe),
    .HIGH_OUT(hi_out),
    .HIGH_OE(hi_oe),
    .LATCH(latch),
    .WRITE_N(wr_n),
    .READ_N(rd_n)
  );
  ext_sram_model u_mem (.clk(clk), .ad(ad_w), .hi(hi_out), .ale(latch), .we_n(wr_n),
    .re_n(rd_n), .q(q), .q_oe(q_oe));

  // undriven lines toggle so a stale value never passes
  assign ad_w = ad_oe[0] ? ad_out : (q_oe ? q : ~ad_last);
  always @(posedge clk) ad_last <= ad_w;
  always #5 clk = ~clk;
  // hang guard, well above the few hundred cycles used
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // external cycle: catch the high byte at latch, then poll busy
  task automatic xcyc(input logic w, input logic [15:0] a, input logic [7:0] d);
    int n;
    apb(1'b1, `ADDR_ACCESS, {7'h0, w, d, a});
    n = 0;
    while (latch !== 1'b1 && n < 8) begin
      @(posedge clk);
      n++;
    end
    hi_seen = hi_out;
    do apb(1'b0, `ADDR_STATUS, 32'h0); while (rd[8] !== 1'b0);
  endtask : xcyc

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk("reset value", 32'h0, rd);
    end
    apb(1'b0, 12'h018, 32'h0);
    chk("unmapped error", 32'h1, 32'(err));
    apb(1'b1, `ADDR_PORT_DIR, 32'hFF);
    apb(1'b1, `ADDR_MEM_CTRL, 32'h1);
    // every mask value, port driving zero on released pins
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, `ADDR_SPECIAL_IO, 32'(k << 3));
      xcyc(1'b1, 16'hFF01, 8'(8'h30 + k));
      hi_exp = (k == 7) ? 8'h00 : 8'(8'hFF >> k);
      chk("high byte", 32'(hi_exp), 32'(hi_seen));
      chk("landing", 32'(8'h30 + k), 32'(u_mem.mem[{hi_exp, 8'h01}]));
    end
    apb(1'b1, `ADDR_SPECIAL_IO, 32'h0);
    xcyc(1'b1, 16'h04FF, 8'h11);
    chk("internal hit", 32'h200, rd & 32'h200);
    xcyc(1'b1, 16'h0500, 8'h22);
    chk("first external", 32'h22, 32'(u_mem.mem[16'h0500]));
    xcyc(1'b1, 16'h8000, 8'hAA);
    xcyc(1'b0, 16'h8000, 8'h00);
    chk("read back", 32'hAA, rd & 32'hFF);
    chk("top line", 32'hAA, 32'(u_mem.mem[16'h8000]));
    apb(1'b1, `ADDR_MEM_CTRL, 32'h3);
    xcyc(1'b1, 16'h045F, 8'h33);
    chk("compat internal", 32'h200, rd & 32'h200);
    xcyc(1'b1, 16'h0460, 8'h44);
    chk("compat external", 32'h44, 32'(u_mem.mem[16'h0460]));
    // keeper holds the read's address low byte, then outlives the interface
    apb(1'b1, `ADDR_SPECIAL_IO, 32'h40);
    xcyc(1'b1, 16'h06A5, 8'h5A);
    xcyc(1'b0, 16'h06A5, 8'h00);
    chk("keeper read", 32'h5A, rd & 32'hFF);
    chk("keeper hold", 32'hFFA5, 32'({ad_oe, ad_out}));
    apb(1'b1, `ADDR_MEM_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    chk("keeper alone", 32'hFFA5, 32'({ad_oe, ad_out}));
    apb(1'b1, `ADDR_SPECIAL_IO, 32'h38);
    repeat (2) @(posedge clk);
    chk("keeper off", 32'h0, 32'(ad_oe));
    apb(1'b1, `ADDR_PORT_DIR, 32'h0F);
    apb(1'b1, `ADDR_PORT_OUT, 32'h05);
    repeat (2) @(posedge clk);
    chk("port pins", 32'h0F05, 32'({hi_oe, hi_out}));
    apb(1'b1, `ADDR_MEM_CTRL, 32'h1);
    apb(1'b1, `ADDR_SPECIAL_IO, 32'h08);
    repeat (2) @(posedge clk);
    chk("pin override", 32'h7F, 32'(hi_oe));
    close_out();
  end
endmodule : testbench
